/* rtl/anp_regs.svh */
// register offsets, field positions and reset values of the next-page bank
`ifndef ANP_REGS_SVH
`define ANP_REGS_SVH

// register indices; byte address is four times the index
`define ANP_EXP_IDX        10'h006
`define ANP_NPT_IDX        10'h007
`define ANP_IRQ_STAT_IDX   10'h008
`define ANP_IRQ_MASK_IDX   10'h009

// expansion register fields
`define ANP_EXP_FAULT_BIT  4
`define ANP_EXP_PNP_BIT    3
`define ANP_EXP_LNP_BIT    2
`define ANP_EXP_PAGE_BIT   1
`define ANP_EXP_PAN_BIT    0

// next-page transmit register fields
`define ANP_NPT_MORE_BIT   15
`define ANP_NPT_ACK_BIT    14
`define ANP_NPT_MSG_BIT    13
`define ANP_NPT_COMPLY_BIT 12
`define ANP_NPT_TOGGLE_BIT 11
`define ANP_NPT_CODE_MSB   10
`define ANP_NPT_WR_MASK    16'hb7ff

// interrupt status and mask fields
`define ANP_IRQ_FAULT_BIT  0
`define ANP_IRQ_PAGE_BIT   1
`define ANP_IRQ_SENT_BIT   2

// reset values
`define ANP_NPT_RESET      16'h0000
`define ANP_IRQ_MASK_RESET 3'h0

`endif

/* rtl/anp_pkg.sv */
// types shared by the next-page register bank
package anp_pkg;

  typedef enum logic [1:0] {
    ANP_TG_BASE = 2'b01,
    ANP_TG_NEXT = 2'b10
  } anp_tg_state_e;

  typedef struct packed {
    anp_tg_state_e phase;
    logic          toggle;
  } anp_tg_s;

  typedef struct packed {
    logic        fault;
    logic        page_arrived;
    logic [15:0] npt_word;
    logic        page_loaded;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [15:0] rd_snap;
    logic [31:0] prdata;
    logic        pslverr;
    logic [15:0] tx_page;
    logic        irq;
  } anp_state_s;

endpackage

/* rtl/anp_tg_if.sv */
// toggle tracking signals between the register bank and its tracker
`timescale 1ns/100ps
interface anp_tg_if;
  logic base_sent;
  logic base_bit11;
  logic page_sent;
  logic toggle;

  modport ctl (output base_sent, output base_bit11, output page_sent,
               input toggle);
  modport trk (input base_sent, input base_bit11, input page_sent,
               output toggle);
endinterface

/* rtl/anp_toggle.sv */
// toggle bit tracker for outgoing next pages
`timescale 1ns/100ps
module anp_toggle (
  input wire logic pclk,
  input wire logic presetn,
  anp_tg_if.trk    tg
);

  anp_pkg::anp_tg_s st;
  anp_pkg::anp_tg_s next_st;

  always_comb begin
    next_st = st;
    case (st.phase)
      anp_pkg::ANP_TG_BASE: begin
        // first next page carries the inverse of base page bit 11
        if (tg.base_sent) begin
          next_st.toggle = ~tg.base_bit11;
          next_st.phase  = anp_pkg::ANP_TG_NEXT;
        end
      end
      anp_pkg::ANP_TG_NEXT: begin
        // a new base page restarts the sequence
        if (tg.base_sent) begin
          next_st.toggle = ~tg.base_bit11;
        end else if (tg.page_sent) begin
          next_st.toggle = ~st.toggle;
        end
      end
      default: begin
        next_st.phase  = anp_pkg::ANP_TG_BASE;
        next_st.toggle = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{phase: anp_pkg::ANP_TG_BASE, toggle: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign tg.toggle = st.toggle;

endmodule

/* rtl/anp_top.sv */
// autonegotiation expansion and next-page transmit register bank
//
// Overview of operation
// - fault flag sets when several technologies report link together while pd_active is high
// - fault flag stays set until the expansion register is read
// - partner next-page bit reads 1 when the partner supports next pages
// - local next-page bit always reads 1
// - page-arrived flag latches on a received page, cleared by read
// - partner autoneg bit reads 1 when the partner supports autoneg
// - more-pages bit: 0 on final page, 1 when another follows
// - acknowledge bit mirrors the acknowledge of the link code word
// - message bit: 0 unformatted page, 1 formatted message page
// - comply bit: 1 when able to comply, 0 when not
// - toggle bit is the inverse of the previous page's toggle
// - first next page toggle is inverse of base page bit 11
// - low 11 bits hold a writable code field, 2048 values
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "anp_regs.svh"
module anp_top #(
  parameter int NUM_TECH = 3,
  parameter int ADDR_W   = 12
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                pd_active,
  input  wire logic [NUM_TECH-1:0] tech_link_ok,
  input  wire logic                np_received,
  input  wire logic                partner_np_capable,
  input  wire logic                partner_autoneg_capable,
  input  wire logic                lcw_ack,
  input  wire logic                base_page_sent,
  input  wire logic                base_bit11,
  input  wire logic                np_exchanged,
  output logic [15:0]              tx_page,
  output logic                     page_loaded,
  output logic                     irq
);

  // elaboration refuses sizes that the decode cannot serve
  if (NUM_TECH < 2) begin
    $error("NUM_TECH must be at least 2");
  end
  if (ADDR_W < 6 || ADDR_W > 32) begin
    $error("ADDR_W must lie between 6 and 32");
  end

  localparam int SEL_EXP  = 0;
  localparam int SEL_NPT  = 1;
  localparam int SEL_STAT = 2;
  localparam int SEL_MASK = 3;

  anp_pkg::anp_state_s st;
  anp_pkg::anp_state_s next_st;

  anp_tg_if tg ();

  anp_toggle u_toggle (
    .pclk    (pclk),
    .presetn (presetn),
    .tg      (tg.trk)
  );

  // toggle tracker follows the exchange strobes directly
  assign tg.base_sent  = base_page_sent;
  assign tg.base_bit11 = base_bit11;
  assign tg.page_sent  = np_exchanged;

  // one-hot register select; word aligned, low two bits ignored
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    logic [3:0]        s;
    idx = a[ADDR_W-1:2];
    s   = 4'h0;
    if (idx == (ADDR_W-2)'(`ANP_EXP_IDX)) begin
      s[SEL_EXP] = 1'b1;
    end
    if (idx == (ADDR_W-2)'(`ANP_NPT_IDX)) begin
      s[SEL_NPT] = 1'b1;
    end
    if (idx == (ADDR_W-2)'(`ANP_IRQ_STAT_IDX)) begin
      s[SEL_STAT] = 1'b1;
    end
    if (idx == (ADDR_W-2)'(`ANP_IRQ_MASK_IDX)) begin
      s[SEL_MASK] = 1'b1;
    end
    return s;
  endfunction

  // true when two or more bits are set
  function automatic logic several_set(input logic [NUM_TECH-1:0] v);
    return |(v & (v - NUM_TECH'(1)));
  endfunction

  // merge a write into stored bits honouring the low two byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be,
                                             input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  logic [3:0]  setup_sel;
  logic [3:0]  acc_sel;
  logic        setup_ph;
  logic        acc_ph;
  logic [15:0] exp_word;
  logic [15:0] npt_word_rd;
  logic        ev_fault;
  logic        ev_page;
  logic [2:0]  irq_events;

  always_comb begin
    setup_ph  = psel && !penable;
    acc_ph    = psel && penable;
    setup_sel = reg_sel(paddr);
    acc_sel   = reg_sel(paddr);

    ev_fault = pd_active && several_set(tech_link_ok);
    ev_page  = np_received;

    exp_word                     = 16'h0000;
    exp_word[`ANP_EXP_FAULT_BIT] = st.fault;
    exp_word[`ANP_EXP_PNP_BIT]   = partner_np_capable;
    exp_word[`ANP_EXP_LNP_BIT]   = 1'b1;
    exp_word[`ANP_EXP_PAGE_BIT]  = st.page_arrived;
    exp_word[`ANP_EXP_PAN_BIT]   = partner_autoneg_capable;

    // stored writable bits plus the live read-only bits
    npt_word_rd                      = st.npt_word;
    npt_word_rd[`ANP_NPT_ACK_BIT]    = lcw_ack;
    npt_word_rd[`ANP_NPT_TOGGLE_BIT] = tg.toggle;

    irq_events                     = 3'h0;
    irq_events[`ANP_IRQ_FAULT_BIT] = ev_fault;
    irq_events[`ANP_IRQ_PAGE_BIT]  = ev_page;
    irq_events[`ANP_IRQ_SENT_BIT]  = np_exchanged;
  end

  always_comb begin
    next_st = st;

    // read data is captured in the setup cycle so it comes from a flop;
    // the read-clear later drops only the bits that were captured, so
    // an event arriving between setup and access is never lost
    if (setup_ph) begin
      next_st.pslverr = ~|setup_sel;
      next_st.prdata  = 32'h0000_0000;
      next_st.rd_snap = 16'h0000;
      if (!pwrite) begin
        case (1'b1)
          setup_sel[SEL_EXP]: begin
            next_st.prdata  = {16'h0000, exp_word};
            next_st.rd_snap = exp_word;
          end
          setup_sel[SEL_NPT]: begin
            next_st.prdata = {16'h0000, npt_word_rd};
          end
          setup_sel[SEL_STAT]: begin
            next_st.prdata  = {29'h0, st.irq_status};
            next_st.rd_snap = {13'h0, st.irq_status};
          end
          setup_sel[SEL_MASK]: begin
            next_st.prdata = {29'h0, st.irq_mask};
          end
          default: begin
            next_st.prdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // read clears of latched flags, set takes priority below
    if (acc_ph && !pwrite && acc_sel[SEL_EXP]) begin
      if (st.rd_snap[`ANP_EXP_FAULT_BIT]) begin
        next_st.fault = 1'b0;
      end
      if (st.rd_snap[`ANP_EXP_PAGE_BIT]) begin
        next_st.page_arrived = 1'b0;
      end
    end
    if (acc_ph && !pwrite && acc_sel[SEL_STAT]) begin
      next_st.irq_status = st.irq_status & ~st.rd_snap[2:0];
    end

    // writes take effect in the access cycle
    if (acc_ph && pwrite) begin
      if (acc_sel[SEL_NPT]) begin
        // more-pages, message, comply and code field are writable
        next_st.npt_word = lane_merge(st.npt_word, pwdata, pstrb,
                                      `ANP_NPT_WR_MASK);
        next_st.page_loaded = 1'b1;
      end
      if (acc_sel[SEL_MASK] && pstrb[0]) begin
        next_st.irq_mask = pwdata[2:0];
      end
    end

    // page was taken by the link; a write in the same cycle keeps it
    if (np_exchanged && !(acc_ph && pwrite && acc_sel[SEL_NPT])) begin
      next_st.page_loaded = 1'b0;
    end

    // hardware sets win over any clear in the same cycle
    if (ev_fault) begin
      next_st.fault = 1'b1;
    end
    if (ev_page) begin
      next_st.page_arrived = 1'b1;
    end
    next_st.irq_status = next_st.irq_status | irq_events;

    // outgoing page word, code field kept in the low eleven bits
    next_st.tx_page = {st.npt_word[`ANP_NPT_MORE_BIT],
                       lcw_ack,
                       st.npt_word[`ANP_NPT_MSG_BIT],
                       st.npt_word[`ANP_NPT_COMPLY_BIT],
                       tg.toggle,
                       st.npt_word[`ANP_NPT_CODE_MSB:0]};

    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.fault        <= 1'b0;
      st.page_arrived <= 1'b0;
      st.npt_word     <= `ANP_NPT_RESET;
      st.page_loaded  <= 1'b0;
      st.irq_status   <= 3'h0;
      st.irq_mask     <= `ANP_IRQ_MASK_RESET;
      st.rd_snap      <= 16'h0000;
      st.prdata       <= 32'h0000_0000;
      st.pslverr      <= 1'b0;
      st.tx_page      <= 16'h0000;
      st.irq          <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready      = 1'b1;
  assign prdata      = st.prdata;
  assign pslverr     = st.pslverr && psel && penable;
  assign tx_page     = st.tx_page;
  assign page_loaded = st.page_loaded;
  assign irq         = st.irq;

endmodule

/* tb/anp_chk_assertions.sv */
// port-level checks on the next-page register bank
`timescale 1ns/100ps
module anp_chk #(parameter int ADDR_W = 12) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              partner_np_capable,
  input wire logic              partner_autoneg_capable,
  input wire logic              lcw_ack,
  input wire logic              base_page_sent,
  input wire logic              base_bit11,
  input wire logic              np_exchanged,
  input wire logic [15:0]       tx_page,
  input wire logic              page_loaded
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  // writes capture zero read data, so only read setups are watched
  wire rd_exp = psel && !penable && !pwrite && paddr == 'h18;
  wire rd_npt = psel && !penable && !pwrite && paddr == 'h1c;
  wire wr_npt = acc && pwrite && paddr == 'h1c;
  wire bad = paddr < 'h18 || paddr > 'h27;
  a_local_np: assert property (rd_exp |=> prdata[2])
    else $error("local next-page bit not set");
  a_partner_caps: assert property (rd_exp |=>
    prdata[3] == $past(partner_np_capable) &&
    prdata[0] == $past(partner_autoneg_capable))
    else $error("partner capability bits wrong");
  a_ack_live: assert property (rd_npt |=> prdata[14] == $past(lcw_ack))
    else $error("acknowledge bit wrong");
  a_first_toggle: assert property (base_page_sent |->
    ##2 tx_page[11] == !$past(base_bit11, 2))
    else $error("first toggle not inverse of base bit");
  a_toggle_flip: assert property (np_exchanged && !base_page_sent |->
    ##2 tx_page[11] != $past(tx_page[11]))
    else $error("toggle did not invert");
  a_loaded_set: assert property (wr_npt |=> page_loaded)
    else $error("page not marked loaded");
  a_loaded_clear: assert property (np_exchanged && !wr_npt |=>
    !page_loaded)
    else $error("page still loaded after exchange");
  a_page_fields: assert property (wr_npt && pstrb[1:0] == 2'b11 |->
    ##2 (tx_page & 16'hb7ff) == ($past(pwdata[15:0], 2) & 16'hb7ff))
    else $error("outgoing page fields differ from write");
  a_unmapped_err: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped access");
endmodule

bind anp_top anp_chk #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr),
  .partner_np_capable(partner_np_capable),
  .partner_autoneg_capable(partner_autoneg_capable),
  .lcw_ack(lcw_ack), .base_page_sent(base_page_sent),
  .base_bit11(base_bit11), .np_exchanged(np_exchanged),
  .tx_page(tx_page), .page_loaded(page_loaded)
);

/* tb/anp_mgmt_model.sv */
// management station model issuing apb transfers
`timescale 1ns/100ps
module anp_mgmt_model #(parameter int ADDR_W = 12) (
  input  wire logic         pclk,
  input  wire logic         pready,
  input  wire logic [31:0]  prdata,
  input  wire logic         pslverr,
  output logic              psel,
  output logic              penable,
  output logic              pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0]       pwdata,
  output logic [3:0]        pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // page word written as given: more, message, comply, code
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* tb/anp_top_tb.sv */
// self-checking bench for the next-page register bank
`timescale 1ns/100ps
module anp_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic pd_active, np_received, pnp, pan, lcw_ack;
  logic base_page_sent, base_bit11, np_exchanged, page_loaded;
  logic [2:0]  tech_link_ok, m_stat, m_mask;
  logic [15:0] tx_page, m_npt;
  logic m_fault, m_page, m_tog, m_ld;
  int err_total, checked;
  anp_mgmt_model #(.ADDR_W(12)) m (.pclk(pclk), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  anp_top #(.NUM_TECH(3), .ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pd_active(pd_active), .tech_link_ok(tech_link_ok),
    .np_received(np_received), .partner_np_capable(pnp),
    .partner_autoneg_capable(pan), .lcw_ack(lcw_ack),
    .base_page_sent(base_page_sent), .base_bit11(base_bit11),
    .np_exchanged(np_exchanged), .tx_page(tx_page),
    .page_loaded(page_loaded), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic wrap_up;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    wrap_up;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      $display("wrong value at %0t: got %h want %h", $time, g, x);
      err_total++;
    end
  endtask
  function automatic logic [31:0] want(input logic [11:0] a);
    case (a)
      12'h018: return {27'h0, m_fault, pnp, 1'b1, m_page, pan};
      12'h01c: return {16'h0, m_npt[15], lcw_ack, m_npt[13:12], m_tog,
                       m_npt[10:0]};
      12'h020: return {29'h0, m_stat};
      12'h024: return {29'h0, m_mask};
      default: return 32'h0;
    endcase
  endfunction
  task automatic xact(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    logic [31:0] q, x;
    logic        e;
    x = want(a);
    m.xfer(w, a, d, q, e);
    chk({31'h0, e}, {31'h0, a < 12'h018 || a > 12'h024});
    if (!w) chk(q, x);
    if (!w && a == 12'h018) {m_fault, m_page} = 2'b00;
    if (!w && a == 12'h020) m_stat = 3'h0;
    if (w && a == 12'h01c) {m_npt, m_ld} = {d[15:0] & 16'hb7ff, 1'b1};
    if (w && a == 12'h024) m_mask = d[2:0];
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, |(m_stat & m_mask)});
    chk({31'h0, page_loaded}, {31'h0, m_ld});
    chk({16'h0, tx_page}, want(12'h01c));
  endtask
  task automatic pulse(input int k);
    @(posedge pclk);
    np_received <= k == 0;
    np_exchanged <= k == 1;
    base_page_sent <= k == 2;
    @(posedge pclk);
    {np_received, np_exchanged, base_page_sent} <= 3'b000;
    if (k == 0) {m_page, m_stat[1]} = 2'b11;
    if (k == 1) {m_tog, m_stat[2], m_ld} = {~m_tog, 2'b10};
    if (k == 2) m_tog = ~base_bit11;
    settle;
  endtask
  initial begin
    {presetn, pd_active, tech_link_ok, np_received, np_exchanged} = '0;
    {base_page_sent, base_bit11, pnp, pan, lcw_ack} = '0;
    {m_fault, m_page, m_tog, m_ld, m_stat, m_mask, m_npt} = '0;
    void'($urandom(32'head85f10));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xact(1'b0, 12'h018, 32'h0);
    xact(1'b0, 12'h01c, 32'h0);
    xact(1'b0, 12'h024, 32'h0);
    xact(1'b1, 12'h030, 32'hffffffff);
    xact(1'b0, 12'h030, 32'h0);
    xact(1'b1, 12'h018, 32'hffffffff);
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      {pd_active, tech_link_ok} <= i[3:0];
      @(posedge pclk);
      pd_active <= 1'b0;
      if (i[3] && $countones(i[2:0]) > 1) {m_fault, m_stat[0]} = 2'b11;
      xact(1'b0, 12'h018, 32'h0);
      xact(1'b0, 12'h018, 32'h0);
    end
    pulse(0);
    xact(1'b0, 12'h018, 32'h0);
    xact(1'b1, 12'h024, 32'h7);
    settle;
    xact(1'b0, 12'h020, 32'h0);
    settle;
    base_bit11 <= $urandom;
    pulse(2);
    for (int i = 0; i < 8; i++) begin
      {pnp, pan, lcw_ack} <= $urandom;
      xact(1'b1, 12'h01c, i == 0 ? 32'hffff : $urandom);
      settle;
      xact(1'b0, 12'h01c, 32'h0);
      xact(1'b0, 12'h018, 32'h0);
      pulse(1);
    end
    base_bit11 <= $urandom;
    pulse(2);
    pulse(1);
    xact(1'b1, 12'h024, 32'h2);
    xact(1'b0, 12'h020, 32'h0);
    pulse(0);
    xact(1'b0, 12'h020, 32'h0);
    settle;
    wrap_up;
  end
endmodule
